// file: design/nav_pkg.sv
// constants, types and decode functions for the two-button navigator
package nav_pkg;
	// clock and the 1 ms timebase
	localparam int CLK_NS    = 10;        // 100 MHz period in ns
	localparam int MS_NS     = 1_000_000; // one millisecond in ns
	localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
	// press timing, in ms
	localparam logic [12:0] DEB_MS      = 13'h000A; // debounce settle
	localparam logic [12:0] LONG_MS     = 13'h03E8; // 1 s long start
	localparam logic [12:0] LONG_MAX_MS = 13'h07D0; // 2 s long end
	localparam logic [12:0] EXT_MS      = 13'h1388; // 5 s extended
	localparam logic [12:0] COMBO_MS    = 13'h0064; // both-button window
	localparam logic [12:0] REFRESH_MS  = 13'h03E8; // normal screen update
	localparam logic [12:0] CLK_REF_MS  = 13'h01F4; // clock screen update
	// auto-return
	localparam logic [20:0] MIN_MS      = 21'h0EA60; // one minute in ms
	localparam logic [4:0]  SETUP_RET   = 5'h05;     // setup menus, minutes
	// displays and menus
	localparam logic [3:0]  NUM_DISP     = 4'h9;
	localparam logic [3:0]  DEFAULT_DISP = 4'h0;
	localparam logic [3:0]  CLOCK_DISP   = 4'h1;
	localparam logic [3:0]  CLOCK_PAGE   = 4'h0;
	localparam logic [3:0]  NUM_MENU     = 4'hE;
	localparam logic [3:0]  PW_MENU      = 4'hA; // password setup item
	localparam logic [3:0]  MAX_DIGITS   = 4'h8;
	localparam logic [3:0]  DIGIT_MAX    = 4'h9;
	localparam logic [2:0]  LAST_POS     = 3'h7;
	// pages per display, display 0 in the low nibble
	localparam logic [35:0] PAGE_TABLE = {4'h3, 4'h4, 4'h2, 4'h6, 4'h8,
		4'h5, 4'h4, 4'h2, 4'h3};
	// displays offering a both-button shortcut, and its menu item
	localparam logic [8:0]  SHORTCUT_MASK = 9'h0F6;
	localparam logic [35:0] SHORTCUT_ITEM = {4'h4, 4'h9, 4'h8, 4'h7, 4'h6,
		4'h5, 4'h3, 4'h2, 4'h0};
	// security level needed per menu item, item 0 in the low bits
	localparam logic [27:0] MENU_LVL = {2'h3, 2'h3, 2'h3, 2'h3, 2'h2,
		2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1};

	// operating mode, gray along data -> menu -> edit
	typedef enum logic [1:0] {
		ST_DATA = 2'b00,
		ST_MENU = 2'b01,
		ST_EDIT = 2'b11
	} mode_e;

	// press duration class
	typedef enum logic [1:0] {
		CLS_SHORT = 2'b00,
		CLS_LONG  = 2'b01,
		CLS_HOLD  = 2'b10,
		CLS_EXT   = 2'b11
	} press_e;

	// page count of a display
	function automatic logic [3:0] pages_of(input logic [3:0] d);
		return PAGE_TABLE[{d, 2'b00} +: 4];
	endfunction : pages_of

	// level a menu item needs
	function automatic logic [1:0] menu_level(input logic [3:0] i);
		return MENU_LVL[{i, 1'b0} +: 2];
	endfunction : menu_level

	// step with wrap to zero at n
	function automatic logic [3:0] inc_wrap(input logic [3:0] v,
		input logic [3:0] n);
		return (v + 4'h1 >= n) ? 4'h0 : v + 4'h1;
	endfunction : inc_wrap

	// class of a finished hold
	function automatic press_e classify(input logic [12:0] h);
		if (h < LONG_MS)
			return CLS_SHORT;
		else if (h <= LONG_MAX_MS)
			return CLS_LONG;
		else if (h < EXT_MS)
			return CLS_HOLD;
		return CLS_EXT;
	endfunction : classify
endpackage : nav_pkg

// file: design/button_if.sv
// debounced button events from a button timer to the navigator
`timescale 1ns/1ps
interface button_if;
	import nav_pkg::*;
	logic   down;  // debounced level
	logic   press; // pulse on press
	logic   rel;   // pulse on release
	logic   ext;   // pulse when hold reaches 5 s
	press_e cls;   // class, valid with rel
	modport src (output down, press, rel, ext, cls);
	modport dst (input down, press, rel, ext, cls);
endinterface : button_if

// file: design/button_timer.sv
// one button: synchroniser, debounce and hold timing
`timescale 1ns/1ps
module button_timer
	import nav_pkg::*;
(
	input  wire logic sys_clk, // system clock
	input  wire logic resetn,  // synchronous reset, low
	input  wire logic ms_tick, // 1 ms enable
	input  wire logic raw,     // button contact, high pressed
	button_if.src     b        // events out
);
	// whole state of the button
	typedef struct packed {
		logic        s1, s2;   // synchroniser
		logic        stable;   // debounced level
		logic [12:0] deb;      // settle counter
		logic [12:0] held;     // hold time
		logic [12:0] held_rel; // hold time at release
		logic        press, rel, ext;
		press_e      cls;
	} btn_s;
	btn_s c, n;

	// next state
	always_comb
	begin
		n = c;
		n.press = 1'b0;
		n.rel = 1'b0;
		n.ext = 1'b0;
		n.s1 = raw;
		n.s2 = c.s1;
		// hold time counts in ms, saturating at extended
		if (c.stable && ms_tick && c.held != EXT_MS)
		begin
			n.held = c.held + 13'h0001;
			n.ext = (c.held + 13'h0001 == EXT_MS);
		end
		// level must settle before it is taken
		if (c.s2 == c.stable)
			n.deb = '0;
		else if (ms_tick)
		begin
			if (c.deb + 13'h0001 >= DEB_MS)
			begin
				n.deb = '0;
				n.stable = c.s2;
				n.press = c.s2;
				n.rel = !c.s2;
				if (c.s2)
					n.held = '0;
				else
				begin
					n.held_rel = c.held;
					n.cls = classify(c.held);
				end
			end
			else
				n.deb = c.deb + 13'h0001;
		end
	end

	// state register
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			c <= '0;
		else
			c <= n;
	end

	assign b.down = c.stable;
	assign b.press = c.press;
	assign b.rel = c.rel;
	assign b.ext = c.ext;
	assign b.cls = c.cls;

	press_gap_a: assert property (@(posedge sys_clk)
		disable iff (!resetn) b.press |=> !b.press [*2])
		else $error("press pulses too close");
	long_class_a: assert property (@(posedge sys_clk)
		disable iff (!resetn) b.rel && b.cls == CLS_LONG |->
		c.held_rel >= LONG_MS && c.held_rel <= LONG_MAX_MS)
		else $error("long class outside 1 to 2 s");
	ext_class_a: assert property (@(posedge sys_clk)
		disable iff (!resetn) b.rel && b.cls == CLS_EXT |->
		c.held_rel >= EXT_MS)
		else $error("extended class under 5 s");
	ext_hit_a: assert property (@(posedge sys_clk)
		disable iff (!resetn) b.ext |-> b.down && c.held == EXT_MS)
		else $error("extended pulse at wrong hold time");
endmodule : button_timer

// file: design/two_button_menu_navigator.sv
// front-panel navigator: press gestures to display and menu position
// Overview of operation
// - hold of one to two seconds is long
// - hold of five seconds or more is extended
// - two modes, data display and programming
// - page button acts at press
// - data mode page button steps page
// - programming page button steps item or digit
// - confirm button acts at release, extended at 5 s of hold
// - confirm short next display, extended enters programming
// - programming confirm short next item or digit, long selects or stores
// - both short returns display to first page
// - both short on clock page toggles test
// - both extended on chosen displays jumps menu
// - nine displays, show display, page, count
// - refresh each second, clock display twice
// - three password levels gate menu items
// - passwords hold one to eight digits
// - press with backlight off only wakes it
// - idle interval returns to default page
`timescale 1ns/1ps
module two_button_menu_navigator
	import nav_pkg::*;
#(
	parameter int MS_CYCLES_P = MS_CYCLES // clocks per ms
)(
	input  wire logic        sys_clk,         // 100 MHz clock
	input  wire logic        resetn,          // synchronous reset, low
	input  wire logic        scroll_btn,      // page button, high pressed
	input  wire logic        confirm_btn,     // confirm button
	input  wire logic        backlight_lit,   // backlight is on
	input  wire logic [1:0]  pw_level,        // 0 none, 1 low, 2 mid, 3 high
	input  wire logic        auto_return_en,  // auto-return enable
	input  wire logic [4:0]  auto_return_min, // data idle minutes
	output logic             backlight_wake,  // pulse, light backlight
	output logic             prog_mode,       // programming mode
	output logic [3:0]       disp_idx,        // current display
	output logic [3:0]       page_idx,        // current page
	output logic [3:0]       page_total,      // pages in display
	output logic             test_view,       // test display shown
	output logic [3:0]       menu_item,       // highlighted item
	output logic [2:0]       edit_digit,      // selected digit
	output logic [3:0]       edit_len,        // digits entered
	output logic [31:0]      edit_val,        // entered digits, bcd
	output logic             value_store,     // pulse, store edit
	output logic             access_denied,   // pulse, level too low
	output logic             refresh_tick     // pulse, redraw screen
);
	// whole state of the navigator
	typedef struct packed {
		mode_e       mode;
		logic [3:0]  disp, page, ptot, item;
		logic        test;
		logic [2:0]  dpos;
		logic [3:0]  dlen;
		logic [31:0] val;
		logic        store, deny, wake, refresh, tick;
		logic [16:0] ms_cnt;   // ms divider
		logic [12:0] rf_ms;    // refresh counter
		logic [12:0] win;      // combo window
		logic [20:0] idle;     // ms since a button was last down
		logic        combo;    // gesture uses both buttons
		logic        swallow;  // gesture only woke backlight
		logic        cext;     // combo already went extended
	} nav_s;
	nav_s c, n;

	// both button timers, 0 page and 1 confirm
	button_if bi[2] ();
	wire logic [1:0] raw = {confirm_btn, scroll_btn};
	for (genvar g = 0; g < 2; g++)
	begin : g_btn
		button_timer u_btn (
			.sys_clk (sys_clk),
			.resetn  (resetn),
			.ms_tick (c.tick),
			.raw     (raw[g]),
			.b       (bi[g])
		);
	end

	logic sp, sd, sr, se, cp, cd, cr, ce; // button events
	press_e scls, ccls;                   // release classes
	logic pair, act, act_r, gend, cshort;
	logic [20:0] limit;                   // auto-return limit
	logic [12:0] period;                  // refresh period
	logic [3:0] dig;                      // digit under edit
	assign sp = bi[0].press;
	assign sd = bi[0].down;
	assign sr = bi[0].rel;
	assign se = bi[0].ext;
	assign scls = bi[0].cls;
	assign cp = bi[1].press;
	assign cd = bi[1].down;
	assign cr = bi[1].rel;
	assign ce = bi[1].ext;
	assign ccls = bi[1].cls;

	// next state
	always_comb
	begin
		n = c;
		n.store = 1'b0;
		n.deny = 1'b0;
		n.wake = 1'b0;
		n.refresh = 1'b0;
		// 1 ms enable
		n.tick = (c.ms_cnt == 17'(MS_CYCLES_P - 1));
		n.ms_cnt = n.tick ? '0 : c.ms_cnt + 17'h00001;
		// second press within window makes a combo
		pair = (sp && cd) || (cp && sd);
		if (pair && (c.win != '0 || (sp && cp)))
			n.combo = 1'b1;
		if ((sp && !cd) || (cp && !sd))
			n.win = COMBO_MS;
		else if (c.tick && c.win != '0)
			n.win = c.win - 13'h0001;
		// press in the dark only lights the backlight
		if ((sp || cp) && !backlight_lit && !c.swallow)
		begin
			n.wake = 1'b1;
			n.swallow = 1'b1;
		end
		act = backlight_lit && !c.swallow && !n.combo;
		act_r = !c.swallow && !c.combo;
		gend = (sr || cr) && !sd && !cd;
		cshort = gend && c.combo && !c.cext && !c.swallow &&
			((sr && scls == CLS_SHORT) || (cr && ccls == CLS_SHORT));
		dig = c.val[{c.dpos, 2'b00} +: 4];
		unique case (c.mode)
			ST_DATA:
			begin
				if (sp && act && !cd)
					n.page = inc_wrap(c.page, c.ptot);
				if (cr && act_r && ccls == CLS_SHORT)
				begin
					n.disp = inc_wrap(c.disp, NUM_DISP);
					n.page = '0;
					n.test = 1'b0;
				end
				if (ce && act_r)
				begin
					n.mode = ST_MENU;
					n.item = '0;
				end
				if ((se || ce) && c.combo && !c.cext && !c.swallow &&
					SHORTCUT_MASK[c.disp])
				begin
					n.mode = ST_MENU;
					n.item = SHORTCUT_ITEM[{c.disp, 2'b00} +: 4];
					n.cext = 1'b1;
				end
				if (cshort)
				begin
					if (c.disp == CLOCK_DISP && c.page == CLOCK_PAGE)
						n.test = !c.test;
					else
						n.page = '0;
				end
			end
			ST_MENU:
			begin
				if (sp && act && !cd)
					n.item = inc_wrap(c.item, NUM_MENU);
				if (cr && act_r && ccls == CLS_SHORT)
					n.item = inc_wrap(c.item, NUM_MENU);
				if (cr && act_r && ccls == CLS_LONG)
				begin
					if (pw_level >= menu_level(c.item))
					begin
						n.mode = ST_EDIT;
						n.val = '0;
						n.dpos = '0;
						n.dlen = 4'h1;
					end
					else
						n.deny = 1'b1;
				end
			end
			ST_EDIT:
			begin
				if (sp && act && !cd)
					n.val[{c.dpos, 2'b00} +: 4] =
						(dig == DIGIT_MAX) ? 4'h0 : dig + 4'h1;
				if (cr && act_r && ccls == CLS_SHORT && c.dpos != LAST_POS)
				begin
					n.dpos = c.dpos + 3'h1;
					if ({1'b0, c.dpos} + 4'h2 > c.dlen)
						n.dlen = {1'b0, c.dpos} + 4'h2;
				end
				if (cr && act_r && ccls == CLS_LONG)
				begin
					n.store = (c.dlen != '0 && c.dlen <= MAX_DIGITS);
					n.mode = ST_MENU;
				end
			end
			default:
				n.mode = ST_DATA;
		endcase
		// gesture over once both buttons are up
		if (gend)
		begin
			n.combo = 1'b0;
			n.swallow = 1'b0;
			n.cext = 1'b0;
			n.win = '0;
		end
		// idle timer and auto-return
		limit = 21'((c.mode == ST_DATA ? auto_return_min : SETUP_RET) *
			MIN_MS);
		if (sp || cp || sd || cd)
			n.idle = '0;
		else if (c.tick && c.idle < limit)
		begin
			n.idle = c.idle + 21'h000001;
			if (auto_return_en && c.idle + 21'h000001 == limit)
			begin
				n.mode = ST_DATA;
				n.disp = DEFAULT_DISP;
				n.page = '0;
				n.test = 1'b0;
			end
		end
		// screen refresh, faster on the clock display
		period = (c.mode == ST_DATA && c.disp == CLOCK_DISP) ?
			CLK_REF_MS : REFRESH_MS;
		if (c.tick)
		begin
			if (c.rf_ms + 13'h0001 >= period)
			begin
				n.refresh = 1'b1;
				n.rf_ms = '0;
			end
			else
				n.rf_ms = c.rf_ms + 13'h0001;
		end
		n.ptot = pages_of(n.disp);
	end

	// state register
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			c <= '0;
			c.ptot <= pages_of(DEFAULT_DISP);
		end
		else
			c <= n;
	end

	assign backlight_wake = c.wake;
	assign prog_mode = (c.mode != ST_DATA);
	assign disp_idx = c.disp;
	assign page_idx = c.page;
	assign page_total = c.ptot;
	assign test_view = c.test;
	assign menu_item = c.item;
	assign edit_digit = c.dpos;
	assign edit_len = c.dlen;
	assign edit_val = c.val;
	assign value_store = c.store;
	assign access_denied = c.deny;
	assign refresh_tick = c.refresh;

	scroll_page_a: assert property (@(posedge sys_clk)
		disable iff (!resetn) sp && !cd && !cr && backlight_lit &&
		!c.swallow && c.mode == ST_DATA |=>
		page_idx == inc_wrap($past(page_idx), $past(page_total)))
		else $error("page press did not step page");
	enter_prog_a: assert property (@(posedge sys_clk)
		disable iff (!resetn) ce && c.mode == ST_DATA && !c.combo &&
		!c.swallow |=> prog_mode)
		else $error("extended confirm did not enter programming");
	combo_home_a: assert property (@(posedge sys_clk)
		disable iff (!resetn) cshort && c.mode == ST_DATA &&
		c.disp != CLOCK_DISP |=> page_idx == 4'h0)
		else $error("both short did not return to first page");
	deny_gate_a: assert property (@(posedge sys_clk)
		disable iff (!resetn) c.mode == ST_MENU && cr && act_r &&
		ccls == CLS_LONG && pw_level < menu_level(c.item) |=>
		access_denied && c.mode == ST_MENU)
		else $error("item selected without enough level");
	wake_only_a: assert property (@(posedge sys_clk)
		disable iff (!resetn) (sp || cp) && !backlight_lit && !c.swallow |=>
		backlight_wake && $stable(page_idx) && $stable(disp_idx))
		else $error("dark press did more than wake");
	pw_length_a: assert property (@(posedge sys_clk)
		disable iff (!resetn) value_store |->
		edit_len >= 4'h1 && edit_len <= MAX_DIGITS)
		else $error("stored value length out of range");
	refresh_bound_a: assert property (@(posedge sys_clk)
		disable iff (!resetn) c.rf_ms < REFRESH_MS)
		else $error("refresh counter passed one second");
endmodule : two_button_menu_navigator

// file: tb/panel_operator.sv
// operator model: two push buttons with contact chatter
`timescale 1ns/1ps
module panel_operator
(
	input  wire logic sys_clk,    // system clock
	output logic      scroll_btn, // page button contact, high pressed
	output logic      confirm_btn // confirm button contact
);
	// both contacts open at time zero
	initial
	begin
		scroll_btn  = 1'b0;
		confirm_btn = 1'b0;
	end

	// chatter for seven clocks, far below the settle time, then settle
	task automatic move(input logic s, input logic c, input logic lvl);
		int k;
		for (k = 0; k < 7; k++)
		begin
			@(negedge sys_clk);
			if (s)
				scroll_btn = lvl ^ k[0];
			if (c)
				confirm_btn = lvl ^ k[0];
		end
	endtask : move

	// close the chosen contacts
	task automatic press(input logic s, input logic c);
		move(s, c, 1'b1);
	endtask : press

	// open the chosen contacts
	task automatic lift(input logic s, input logic c);
		move(s, c, 1'b0);
	endtask : lift
endmodule : panel_operator

// file: tb/test_two_button_menu_navigator.sv
// self-checking bench for the two-button navigator
`timescale 1ns/1ps
module test_two_button_menu_navigator;
	localparam int MSP = 2; // clocks per ms in this run

	logic        sys_clk         = 1'b0;  // clock
	logic        resetn          = 1'b0;  // reset, low
	logic        backlight_lit   = 1'b1;  // backlight on
	logic [1:0]  pw_level        = 2'h0;  // password level
	logic        auto_return_en  = 1'b0;  // idle return off
	logic [4:0]  auto_return_min = 5'h00; // idle minutes
	logic        scroll_btn;              // page contact
	logic        confirm_btn;             // confirm contact
	logic        backlight_wake;          // wake pulse
	logic        prog_mode;               // programming mode
	logic [3:0]  disp_idx;                // display
	logic [3:0]  page_idx;                // page
	logic [3:0]  page_total;              // page count
	logic        test_view;               // test display
	logic [3:0]  menu_item;               // menu item
	logic [2:0]  edit_digit;              // digit position
	logic [3:0]  edit_len;                // digits entered
	logic [31:0] edit_val;                // entered digits
	logic        value_store;             // store pulse
	logic        access_denied;           // refusal pulse
	logic        refresh_tick;            // redraw pulse

	// model: pages, shortcut items and levels per item
	int pages[9] = '{3, 2, 4, 5, 8, 6, 2, 4, 3};
	int cut[9]   = '{0, 2, 3, 5, 6, 7, 8, 9, 4};
	int lvl[14]  = '{1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3};
	int md, dsp, pg, itm, tst, dg, ev; // mode 0 data 1 menu 2 edit
	int e_wake, e_store, e_deny;       // expected pulse counts
	int c_wake, c_store, c_deny, c_ref; // seen pulse counts
	int n_fail, checks_done, cycles, k, seed;

	two_button_menu_navigator #(.MS_CYCLES_P(MSP))
		i_two_button_menu_navigator (.sys_clk(sys_clk), .resetn(resetn),
		.scroll_btn(scroll_btn), .confirm_btn(confirm_btn),
		.backlight_lit(backlight_lit), .pw_level(pw_level),
		.auto_return_en(auto_return_en),
		.auto_return_min(auto_return_min),
		.backlight_wake(backlight_wake), .prog_mode(prog_mode),
		.disp_idx(disp_idx), .page_idx(page_idx),
		.page_total(page_total), .test_view(test_view),
		.menu_item(menu_item), .edit_digit(edit_digit),
		.edit_len(edit_len), .edit_val(edit_val),
		.value_store(value_store), .access_denied(access_denied),
		.refresh_tick(refresh_tick));

	panel_operator i_panel_operator (.sys_clk(sys_clk),
		.scroll_btn(scroll_btn), .confirm_btn(confirm_btn));

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	// count pulses and cut a hang short
	always @(posedge sys_clk)
	begin
		c_wake  += int'(backlight_wake === 1'b1);
		c_store += int'(value_store === 1'b1);
		c_deny  += int'(access_denied === 1'b1);
		c_ref   += int'(refresh_tick === 1'b1);
		cycles++;
		if (cycles > 80000)
		begin
			n_fail++;
			test_done();
		end
	end

	// verdict and end of run
	task automatic test_done();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done

	// compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// compare the state outputs with the model, menu item outside data mode and edit outputs in edit mode only
	task automatic chk_state();
		chk(prog_mode, md != 0);
		chk(disp_idx, dsp);
		chk(page_idx, pg);
		chk(page_total, pages[dsp]);
		chk(test_view, tst);
		if (md != 0)
			chk(menu_item, itm);
		if (md == 2)
		begin
			chk(edit_digit, dg);
			chk(edit_len, dg + 1);
			chk(edit_val, ev);
		end
	endtask : chk_state

	// wait a number of ms
	task automatic wait_ms(input int ms);
		repeat (ms * MSP) @(negedge sys_clk);
	endtask : wait_ms

	// model effect of a gesture held h ms
	task automatic apply(input logic s, input logic c, input int h);
		int d;
		d = (ev >> (4 * dg)) & 15;
		if (!backlight_lit)
			e_wake++;
		else if (s && c)
		begin
			if (md == 0 && h >= 5000 && dsp inside {1, 2, 4, 5, 6, 7})
			begin
				md  = 1;
				itm = cut[dsp];
			end
			else if (md == 0 && h < 1000 && dsp == 1 && pg == 0)
				tst ^= 1;
			else if (md == 0 && h < 1000)
				pg = 0;
		end
		else if (s)
		begin
			if (md == 0)
				pg = (pg + 1) % pages[dsp];
			else if (md == 1)
				itm = (itm + 1) % 14;
			else
				ev = (ev & ~(15 << (4 * dg))) | (((d + 1) % 10) << (4 * dg));
		end
		else if (h >= 5000 && md == 0)
		begin
			md  = 1;
			itm = 0;
		end
		else if (h < 1000)
		begin
			if (md == 0)
			begin
				dsp = (dsp + 1) % 9;
				pg  = 0;
				tst = 0;
			end
			else if (md == 1)
				itm = (itm + 1) % 14;
			else if (dg < 7)
				dg++;
		end
		else if (h <= 2000 && md == 1 && pw_level >= lvl[itm])
		begin
			md = 2;
			dg = 0;
			ev = 0;
		end
		else if (h <= 2000 && md == 1)
			e_deny++;
		else if (h <= 2000 && md == 2)
		begin
			e_store++;
			md = 1;
		end
	endtask : apply

	// one gesture: confirm leads a both-button press by 20 ms
	task automatic gesture(input logic s, input logic c, input int h);
		if (s && c)
		begin
			i_panel_operator.press(1'b0, 1'b1);
			wait_ms(20);
			i_panel_operator.press(1'b1, 1'b0);
		end
		else
			i_panel_operator.press(s, c);
		wait_ms(h);
		i_panel_operator.lift(s, c);
		wait_ms(30);
		apply(s, c, h);
		chk_state();
	endtask : gesture

	// reset for 16 cycles and clear the model
	task automatic do_reset();
		resetn = 1'b0;
		repeat (16) @(negedge sys_clk);
		resetn = 1'b1;
		{md, dsp, pg, itm, tst, dg, ev} = '0;
		chk_state();
	endtask : do_reset

	// redraw pulses in a 4 s window
	task automatic ref_count(input int n);
		int c0;
		c0 = c_ref;
		wait_ms(4000);
		chk(c_ref - c0, n);
	endtask : ref_count

	// main sequence
	initial
	begin
		seed = $urandom(32'h4814);
		do_reset();
		i_panel_operator.press(1'b1, 1'b0);
		wait_ms(30);
		apply(1'b1, 1'b0, 0);
		chk_state();
		wait_ms(1500);
		i_panel_operator.lift(1'b1, 1'b0);
		wait_ms(30);
		chk_state();
		repeat (3) gesture(1'b1, 1'b0, 80);
		gesture(1'b1, 1'b1, 80);
		gesture(1'b0, 1'b1, 2500);
		ref_count(4);
		for (k = 0; k < 10; k++)
			gesture(1'b0, 1'b1, 80);
		ref_count(8);
		gesture(1'b1, 1'b1, 80);
		gesture(1'b1, 1'b1, 80);
		backlight_lit = 1'b0;
		gesture(1'b1, 1'b0, 80);
		backlight_lit = 1'b1;
		chk(c_wake, e_wake);
		gesture(1'b0, 1'b1, 5200);
		gesture(1'b1, 1'b0, 80);
		gesture(1'b0, 1'b1, 80);
		for (k = 0; k < 6 && md != 2; k++)
		begin
			// first try has no password so a refusal is always seen
			pw_level = (k == 0) ? 2'h0 :
				(k == 5) ? 2'h3 : 2'($urandom_range(3));
			gesture(1'b0, 1'b1, 1500);
		end
		chk(c_deny, e_deny);
		repeat (3) gesture(1'b1, 1'b0, 80);
		repeat (8) gesture(1'b0, 1'b1, 80);
		gesture(1'b1, 1'b0, 80);
		gesture(1'b0, 1'b1, 1500);
		chk(c_store, e_store);
		do_reset();
		repeat (2) gesture(1'b0, 1'b1, 80);
		gesture(1'b1, 1'b1, 5200);
		test_done();
	end
endmodule : test_two_button_menu_navigator
